//--- bench/rucc_loader_model.sv
`default_nettype none

module rucc_loader_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // loader pins
    input  wire logic       start,
    output logic            done,
    output logic            err,
    output logic            ru,
    // scenario controls
    input  wire logic       fail_cfg,
    input  wire logic       ru_cfg,
    input  wire logic [7:0] delay_cfg
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_q;

    ////////////////////////////////////////////////////////////////
    // finish a load after delay_cfg cycles; done drops once start is gone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            done  <= 1'h0;
            err   <= 1'h0;
            ru    <= 1'h0;
        end else if (!start) begin
            cnt_q <= 8'h00;
            done  <= 1'h0;
            err   <= ~err;  // no meaning without done: keep it moving
            ru    <= ~ru;
        end else if (cnt_q == delay_cfg) begin
            done <= 1'h1;
            err  <= fail_cfg;  // failure only when a scenario asks for it
            ru   <= ru_cfg;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            err   <= ~err;
            ru    <= ~ru;
        end
    end
endmodule : rucc_loader_model

`default_nettype wire

//--- bench/testbench.sv
`default_nettype none

module testbench
    import rucc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICK = 2;

    logic              mclk, rst_n, wr, rd, req_n, fail_cfg, ru_cfg;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic [PAGE_W-1:0] ld_page;
    logic              ld_start, ld_done, ld_err, ld_ru, user_mode, wd_active, irq;
    logic [7:0]        delay_cfg;
    int                err_count, checked;

    ////////////////////////////////////////////////////////////////
    // block under test and the loader beside it
    rucc_top #(.TICK_CYC(TICK)) dut (
        .MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .LOAD_START(ld_start), .LOAD_PAGE(ld_page), .LOAD_DONE(ld_done),
        .LOAD_ERR(ld_err), .LOAD_RU(ld_ru), .RECONF_REQ_N(req_n),
        .USER_MODE(user_mode), .WD_ACTIVE(wd_active), .IRQ(irq));
    rucc_loader_model loader (
        .clk(mclk), .rst_n(rst_n), .start(ld_start), .done(ld_done), .err(ld_err),
        .ru(ld_ru), .fail_cfg(fail_cfg), .ru_cfg(ru_cfg), .delay_cfg(delay_cfg));

    // 200 MHz clock
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [DATA_W-1:0] exp, got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        wr    <= 1'h1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'h0;
    endtask : bus_wr

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        rd   <= 1'h1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'h0;
        #1 v = rdata;
    endtask : bus_rd

    // bounded wait for a level, then judge it
    task automatic wait_for(ref logic s, input logic val, input string nm);
        int n;
        n = 0;
        while (s !== val && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk(nm, 32'(val), 32'(s));
    endtask : wait_for

    task automatic st(input logic [1:0] mode, input logic [2:0] cause);
        bus_rd(OFF_STATUS);
        chk("mode", 32'(mode), 32'(v[1:0]));
        if (mode == 2'h0) chk("cause", 32'(cause), 32'(v[6:4]));
    endtask : st

    task automatic load(input logic [7:0] pg, input logic en, input logic [15:0] tmo,
                        input logic fail, input logic ru, input logic [7:0] dly);
        fail_cfg  <= fail;
        ru_cfg    <= ru;
        delay_cfg <= dly;
        bus_wr(OFF_CTRL, {tmo, 7'h00, en, pg});
        bus_wr(OFF_CMD, 32'h0000_0001);
        wait_for(ld_start, 1'h1, "load_start");
        chk("load_page", 32'(pg), 32'(ld_page));
    endtask : load

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        st(2'h0, 3'h0);
        chk("wd_active", 32'h0, 32'(wd_active));
        bus_rd(8'h20);
        chk("unmapped", 32'h0, v);
        bus_wr(OFF_CMD, 32'h0000_0002);
        chk("user_mode", 32'h0, 32'(user_mode));
    endtask : t_reset

    // cleared in time, then left alone until it bites; mask still zero
    task automatic t_wdog();
        load(8'h5a, 1'h1, 16'h0004, 1'h0, 1'h1, 8'h0c);
        wait_for(user_mode, 1'h1, "user_mode");
        chk("wd_active", 32'h1, 32'(wd_active));
        st(2'h2, 3'h0);
        chk("st_page", 32'h5a, 32'(v[23:16]));
        chk("st_ru_wden", 32'h3, 32'(v[9:8]));
        repeat (10) begin
            bus_wr(OFF_CMD, 32'h0000_0002);
            cyc(2);
        end
        cyc(3);
        chk("user_kept", 32'h1, 32'(user_mode));
        wait_for(user_mode, 1'h0, "user_mode");
        st(2'h0, 3'h3);
        chk("wd_off", 32'h0, 32'(wd_active));
        chk("irq_masked", 32'h0, 32'(irq));
        bus_rd(OFF_IRQ_STS);
        chk("irq_sts", 32'h3, 32'(v[1:0]));
        bus_rd(OFF_IRQ_STS);
        chk("irq_clr", 32'h0, v);
    endtask : t_wdog

    // an image not built for remote update cannot hold the watchdog off
    task automatic t_noru();
        bus_wr(OFF_IRQ_MASK, 32'h0000_000f);
        bus_rd(OFF_IRQ_MASK);
        chk("irq_mask", 32'hf, v);
        load(8'h21, 1'h1, 16'h0004, 1'h0, 1'h0, 8'h01);
        wait_for(user_mode, 1'h1, "user_mode");
        cyc(2);
        chk("irq_user", 32'h1, 32'(irq));
        bus_rd(OFF_IRQ_STS);
        repeat (6) begin
            bus_wr(OFF_CMD, 32'h0000_0002);
            cyc(2);
        end
        chk("user_mode", 32'h0, 32'(user_mode));
        st(2'h0, 3'h3);
        chk("irq_wdog", 32'h1, 32'(irq));
        bus_rd(OFF_IRQ_STS);
        chk("sts_wdog", 32'h1, 32'(v[IRQ_WDOG_BIT]));
        cyc(2);
        chk("irq_low", 32'h0, 32'(irq));
    endtask : t_noru

    task automatic t_err();
        load(8'h33, 1'h1, 16'h0004, 1'h1, 1'h1, 8'h05);
        st(2'h1, 3'h0);
        wait_for(ld_start, 1'h0, "load_start");
        cyc(2);
        chk("user_mode", 32'h0, 32'(user_mode));
        st(2'h0, 3'h4);
        chk("wd_off", 32'h0, 32'(wd_active));
        bus_rd(OFF_IRQ_STS);
        chk("sts_lerr", 32'h4, v);
    endtask : t_err

    // watchdog off: user mode lasts; user logic then asks for factory
    task automatic t_nowd();
        load(8'h44, 1'h0, 16'h0002, 1'h0, 1'h1, 8'h03);
        wait_for(user_mode, 1'h1, "user_mode");
        chk("wd_active", 32'h0, 32'(wd_active));
        bus_rd(OFF_WD_COUNT);
        chk("wd_count", 32'h2, v);
        bus_rd(OFF_CTRL);
        chk("ctrl", 32'h0002_0044, v);
        cyc(40);
        chk("user_kept", 32'h1, 32'(user_mode));
        bus_wr(OFF_CMD, 32'h0000_0004);
        wait_for(user_mode, 1'h0, "user_mode");
        st(2'h0, 3'h2);
        bus_rd(OFF_IRQ_STS);
        chk("sts_reconf", 32'h9, v);
    endtask : t_nowd

    task automatic t_ext();
        load(8'h55, 1'h1, 16'h0040, 1'h0, 1'h1, 8'h02);
        wait_for(user_mode, 1'h1, "user_mode");
        req_n <= 1'h0;
        cyc(6);
        req_n <= 1'h1;
        wait_for(user_mode, 1'h0, "user_mode");
        st(2'h0, 3'h1);
        chk("wd_off", 32'h0, 32'(wd_active));
        load(8'h66, 1'h1, 16'h0040, 1'h0, 1'h1, 8'h02);
        wait_for(user_mode, 1'h1, "user_mode");
        rst_n <= 1'h0;
        cyc(2);
        chk("rst_user", 32'h0, 32'(user_mode));
        rst_n <= 1'h1;
        cyc(6);
        st(2'h0, 3'h0);
    endtask : t_ext

    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // main sequence
    initial begin
        {rst_n, wr, rd, fail_cfg, ru_cfg} = 5'h00;
        req_n     = 1'h1;
        addr      = '0;
        wdata     = '0;
        delay_cfg = 8'h01;
        err_count = 0;
        checked   = 0;
        cyc(6);
        rst_n <= 1'h1;
        cyc(6);
        t_reset();
        t_wdog();
        t_noru();
        t_err();
        t_nowd();
        t_ext();
        report_and_stop();
    end

    // watchdog against a hang, far beyond the few hundred cycles needed
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire

//--- design/rucc_pkg.sv
`default_nettype none

package rucc_pkg;

    // widths of the register port and of the fields
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int PAGE_W  = 8;
    localparam int TMO_W   = 16;
    localparam int IRQ_W   = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STS  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_WD_COUNT = 8'h14;

    // update-control register fields
    localparam int CTRL_PAGE_LSB = 0;
    localparam int CTRL_WDEN_BIT = 8;
    localparam int CTRL_TMO_LSB  = 16;

    // command register bits (write-only pulses)
    localparam int CMD_LOAD_BIT   = 0;
    localparam int CMD_CLEAR_BIT  = 1;
    localparam int CMD_RECONF_BIT = 2;

    // status register fields
    localparam int ST_MODE_LSB  = 0;
    localparam int ST_CAUSE_LSB = 4;
    localparam int ST_RU_BIT    = 8;
    localparam int ST_WDEN_BIT  = 9;
    localparam int ST_PAGE_LSB  = 16;

    // interrupt status and mask bits
    localparam int IRQ_USER_BIT   = 0;
    localparam int IRQ_WDOG_BIT   = 1;
    localparam int IRQ_LERR_BIT   = 2;
    localparam int IRQ_RECONF_BIT = 3;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 4'h0;
    localparam logic [3:0]        PIN_RST      = 4'h8;

    // timing: watchdog tick derived from the 200 MHz clock
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WD_TICK_NS    = 1000;
    localparam int WD_TICK_CYC   = (WD_TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {ST_FACTORY, ST_LOADING, ST_USER} rucc_state_t;

    typedef enum logic [2:0] {
        CAUSE_POWER_UP,
        CAUSE_EXT_REQ,
        CAUSE_USER_REQ,
        CAUSE_WDOG,
        CAUSE_LOAD_ERR
    } rucc_cause_t;

    // address match used by every register decode
    function automatic logic rucc_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction : rucc_hit

endpackage : rucc_pkg

`default_nettype wire

//--- design/rucc_sync.sv
`default_nettype none

module rucc_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // asynchronous in, filtered out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // three stages; a bit changes once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
        end
    end
endmodule : rucc_sync

`default_nettype wire

//--- design/rucc_top.sv
`default_nettype none

module rucc_top
    import rucc_pkg::*;
#(
    parameter int TICK_CYC = WD_TICK_CYC
) (
    // clock and reset
    input  wire logic              MCLK,
    input  wire logic              RST_N,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    // configuration loader
    output logic                   LOAD_START,
    output logic      [PAGE_W-1:0] LOAD_PAGE,
    input  wire logic              LOAD_DONE,
    input  wire logic              LOAD_ERR,
    input  wire logic              LOAD_RU,
    // external reconfiguration request
    input  wire logic              RECONF_REQ_N,
    // status
    output logic                   USER_MODE,
    output logic                   WD_ACTIVE,
    output logic                   IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    rucc_state_t       state_q;
    rucc_state_t       state_d;
    rucc_cause_t       cause_q;
    rucc_cause_t       cause_d;
    logic [DATA_W-1:0] ctrl_q;
    logic [PAGE_W-1:0] page_q;
    logic              app_wd_en_q;
    logic [TMO_W-1:0]  app_tmo_q;
    logic              app_ru_q;
    logic [IRQ_W-1:0]  irq_sts_q;
    logic [IRQ_W-1:0]  irq_sts_d;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [IRQ_W-1:0]  irq_ev;
    logic              req_prev_q;
    logic [3:0]        pins_s;
    logic              done_s;
    logic              err_s;
    logic              ru_s;
    logic              req_s;
    logic              req_rise;
    logic              cmd_load;
    logic              cmd_clear;
    logic              cmd_reconf;
    logic              start_acc;
    logic              leave;
    logic [DATA_W-1:0] st_word;
    logic [DATA_W-1:0] rd_word;

    rucc_wdog_if #(.TMO_W(TMO_W)) wdi ();

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and watchdog counter

    rucc_sync #(.W(4), .RST_VAL(PIN_RST)) u_sync (
        .clk   (MCLK),
        .rst_n (RST_N),
        .d     ({RECONF_REQ_N, LOAD_RU, LOAD_ERR, LOAD_DONE}),
        .q     (pins_s)
    );

    assign done_s   = pins_s[0];
    assign err_s    = pins_s[1];
    assign ru_s     = pins_s[2];
    assign req_s    = !pins_s[3];
    assign req_rise = req_s && !req_prev_q;

    rucc_wdog #(.TICK_CYC(TICK_CYC)) u_wdog (
        .clk   (MCLK),
        .rst_n (RST_N),
        .wdi   (wdi)
    );

    // counter runs only for an application in user mode with watchdog on
    assign wdi.run   = (state_q == ST_USER) && app_wd_en_q;
    assign wdi.tmo   = app_tmo_q;
    // a clear counts only from a remote-update application in user mode
    assign wdi.clear = cmd_clear && (state_q == ST_USER) && app_ru_q;

    ////////////////////////////////////////////////////////////////////////////
    // command strobes

    assign cmd_load   = WR && rucc_hit(ADDR, OFF_CMD) && WDATA[CMD_LOAD_BIT];
    assign cmd_clear  = WR && rucc_hit(ADDR, OFF_CMD) && WDATA[CMD_CLEAR_BIT];
    assign cmd_reconf = WR && rucc_hit(ADDR, OFF_CMD) && WDATA[CMD_RECONF_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: factory -> loading -> user, with every fallback

    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        if (req_rise) begin
            state_d = ST_FACTORY;
            cause_d = CAUSE_EXT_REQ;
        end else begin
            unique case (state_q)
                ST_FACTORY: begin
                    if (cmd_load && !done_s && !req_s) begin
                        state_d = ST_LOADING;
                    end
                end
                ST_LOADING: begin
                    if (done_s && err_s) begin
                        state_d = ST_FACTORY;
                        cause_d = CAUSE_LOAD_ERR;
                    end else if (done_s) begin
                        state_d = ST_USER;
                    end
                end
                ST_USER: begin
                    if (wdi.expired) begin
                        state_d = ST_FACTORY;
                        cause_d = CAUSE_WDOG;
                    end else if (cmd_reconf) begin
                        state_d = ST_FACTORY;
                        cause_d = CAUSE_USER_REQ;
                    end
                end
            endcase
        end
    end

    assign start_acc = (state_q == ST_FACTORY) && (state_d == ST_LOADING);
    assign leave     = (state_d == ST_FACTORY) && ((state_q != ST_FACTORY) || req_rise);

    // state, cause and mode outputs
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q    <= ST_FACTORY;
            cause_q    <= CAUSE_POWER_UP;
            req_prev_q <= 1'b0;
            LOAD_START <= 1'b0;
            USER_MODE  <= 1'b0;
            WD_ACTIVE  <= 1'b0;
        end else begin
            state_q    <= state_d;
            cause_q    <= cause_d;
            req_prev_q <= req_s;
            LOAD_START <= (state_d == ST_LOADING);
            USER_MODE  <= (state_d == ST_USER);
            WD_ACTIVE  <= (state_d == ST_USER) && app_wd_en_q;
        end
    end

    // page, watchdog enable and timeout latched as a load starts, remote-update flag on entry to user; enable and flag cleared in factory mode
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            page_q      <= '0;
            app_wd_en_q <= 1'b0;
            app_tmo_q   <= '0;
            app_ru_q    <= 1'b0;
        end else begin
            if (start_acc) begin
                page_q      <= ctrl_q[CTRL_PAGE_LSB +: PAGE_W];
                app_wd_en_q <= ctrl_q[CTRL_WDEN_BIT];
                app_tmo_q   <= ctrl_q[CTRL_TMO_LSB +: TMO_W];
            end else if (state_d == ST_FACTORY) begin
                app_wd_en_q <= 1'b0;
            end
            if (state_q == ST_LOADING && state_d == ST_USER) begin
                app_ru_q <= ru_s;
            end else if (state_d == ST_FACTORY) begin
                app_ru_q <= 1'b0;
            end
        end
    end

    assign LOAD_PAGE = page_q;

    ////////////////////////////////////////////////////////////////////////////
    // update-control register

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= CTRL_RST;
        end else if (WR && rucc_hit(ADDR, OFF_CTRL)) begin
            ctrl_q <= WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, cleared by its read; a new event wins

    always_comb begin
        irq_ev                 = '0;
        irq_ev[IRQ_USER_BIT]   = (state_q == ST_LOADING) && (state_d == ST_USER);
        irq_ev[IRQ_WDOG_BIT]   = leave && (cause_d == CAUSE_WDOG);
        irq_ev[IRQ_LERR_BIT]   = leave && (cause_d == CAUSE_LOAD_ERR);
        irq_ev[IRQ_RECONF_BIT] = leave && ((cause_d == CAUSE_EXT_REQ) ||
                                           (cause_d == CAUSE_USER_REQ));
        irq_sts_d = irq_sts_q;
        if (RD && rucc_hit(ADDR, OFF_IRQ_STS)) begin
            irq_sts_d = '0;
        end
        irq_sts_d = irq_sts_d | irq_ev;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_sts_q  <= '0;
            irq_mask_q <= IRQ_MASK_RST;
            IRQ        <= 1'b0;
        end else begin
            irq_sts_q <= irq_sts_d;
            if (WR && rucc_hit(ADDR, OFF_IRQ_MASK)) begin
                irq_mask_q <= WDATA[IRQ_W-1:0];
            end
            IRQ <= |(irq_sts_d & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: data stands only in the cycle after the strobe

    always_comb begin
        st_word                               = '0;
        st_word[ST_MODE_LSB +: 2]             = state_q;
        st_word[ST_CAUSE_LSB +: 3]            = cause_q;
        st_word[ST_RU_BIT]                    = app_ru_q;
        st_word[ST_WDEN_BIT]                  = app_wd_en_q;
        st_word[ST_PAGE_LSB +: PAGE_W]        = page_q;
        rd_word = '0;
        if (rucc_hit(ADDR, OFF_CTRL)) begin
            rd_word = ctrl_q;
        end else if (rucc_hit(ADDR, OFF_STATUS)) begin
            rd_word = st_word;
        end else if (rucc_hit(ADDR, OFF_IRQ_STS)) begin
            rd_word[IRQ_W-1:0] = irq_sts_q;
        end else if (rucc_hit(ADDR, OFF_IRQ_MASK)) begin
            rd_word[IRQ_W-1:0] = irq_mask_q;
        end else if (rucc_hit(ADDR, OFF_WD_COUNT)) begin
            rd_word[TMO_W-1:0] = wdi.count;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= '0;
        end else begin
            RDATA <= RD ? rd_word : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_load_ok;
        (state_q == ST_LOADING) && done_s && !err_s && !req_rise;
    endsequence

    sequence s_load_bad;
        (state_q == ST_LOADING) && done_s && err_s && !req_rise;
    endsequence

    sequence s_wd_expire;
        (state_q == ST_USER) && wdi.expired && !req_rise;
    endsequence

    page_latch_a: assert property (start_acc |=> ##1 LOAD_PAGE == $past(ctrl_q[7:0], 2))
        else $error("load page differs from update-control page");

    wden_latch_a: assert property (start_acc |=> app_wd_en_q == $past(ctrl_q[8]))
        else $error("watchdog enable not taken at load start");

    tmo_latch_a: assert property (start_acc |=> app_tmo_q == $past(ctrl_q[31:16]))
        else $error("watchdog timeout not taken at load start");

    clear_gate_a: assert property (wdi.clear |-> app_ru_q && USER_MODE)
        else $error("watchdog cleared outside a remote-update application");

    wdog_fall_a: assert property (s_wd_expire |=> (state_q == ST_FACTORY) &&
                                  (cause_q == CAUSE_WDOG) ##1 !USER_MODE)
        else $error("watchdog expiry did not fall back to factory");

    factory_wd_off_a: assert property ((state_q == ST_FACTORY) |->
                                       !app_wd_en_q ##1 !WD_ACTIVE)
        else $error("watchdog enabled in factory configuration");

    load_err_a: assert property (s_load_bad |=> (state_q == ST_FACTORY) &&
                                 (cause_q == CAUSE_LOAD_ERR) && !LOAD_START)
        else $error("load error did not record cause and reload factory");

    load_ok_a: assert property (s_load_ok |=> (state_q == ST_USER) && USER_MODE &&
                                !LOAD_START)
        else $error("clean load did not enter user mode");

    ext_req_a: assert property (req_rise |=> (state_q == ST_FACTORY) &&
                                (cause_q == CAUSE_EXT_REQ) && !app_wd_en_q)
        else $error("external request did not restart in factory mode");

    irq_sticky_a: assert property (|irq_ev |=> |(irq_sts_q & $past(irq_ev)))
        else $error("interrupt event lost");

endmodule : rucc_top

`default_nettype wire

//--- design/rucc_wdog.sv
`default_nettype none

module rucc_wdog
    import rucc_pkg::*;
#(
    parameter int TICK_CYC = WD_TICK_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // controller side
    rucc_wdog_if.wd   wdi
);
    localparam int DIV_W = $clog2(TICK_CYC + 1);

    logic [DIV_W-1:0] div_q;
    logic [TMO_W-1:0] count_q;
    logic             exp_q;
    logic             tick;

    assign tick        = wdi.run && !wdi.clear && (div_q == DIV_W'(TICK_CYC - 1));
    assign wdi.count   = count_q;
    assign wdi.expired = exp_q;

    // tick divider, restarted by a clear or while idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (!wdi.run || wdi.clear || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // countdown; reload on clear, hold loaded while idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            exp_q   <= 1'b0;
        end else begin
            exp_q <= 1'b0;
            if (!wdi.run || wdi.clear) begin
                count_q <= wdi.tmo;
            end else if (tick) begin
                if (count_q == '0) begin
                    exp_q <= 1'b1;
                end else begin
                    count_q <= count_q - 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    clear_reload_a: assert property (wdi.clear |=> count_q == $past(wdi.tmo))
        else $error("watchdog clear did not reload the timeout");
    idle_quiet_a: assert property (!wdi.run ##1 !wdi.run |-> !exp_q)
        else $error("watchdog expired while not running");

endmodule : rucc_wdog

`default_nettype wire

//--- design/rucc_wdog_if.sv
`default_nettype none

// controller <-> watchdog counter
interface rucc_wdog_if #(parameter int TMO_W = 16);
    logic             run;
    logic             clear;
    logic [TMO_W-1:0] tmo;
    logic             expired;
    logic [TMO_W-1:0] count;

    modport ctl (output run, clear, tmo, input expired, count);
    modport wd  (input run, clear, tmo, output expired, count);
endinterface : rucc_wdog_if

`default_nettype wire
